// ---- mia_pkg.sv ----
/*
  package for the management interrupt aggregator: register indices,
  field positions and reset values.
  assumes an 8-bit configuration register port with index addressing.
*/
package mia_pkg;
  localparam logic [7:0] MIA_IDX_EN_A = 8'hB4;
  localparam logic [7:0] MIA_IDX_EN_B = 8'hB5;
  localparam logic [7:0] MIA_IDX_ST_A = 8'hB6;
  localparam logic [7:0] MIA_IDX_ST_B = 8'hB7;
  localparam logic [7:0] MIA_IDX_RSVD = 8'hB8;
  localparam logic [7:0] MIA_IDX_PMUX = 8'hC0;
  localparam logic [7:0] MIA_IDX_FMC = 8'hC1;
  localparam logic [7:0] MIA_RST_ZERO = 8'h00;
  localparam logic [7:0] MIA_RST_PMUX = 8'h02;
  localparam logic [7:0] MIA_RST_FMC = 8'h03;
  // writable bits of the a and b enable registers and the pin mux register
  localparam logic [7:0] MIA_EN_A_MASK = 8'h9E;
  localparam logic [7:0] MIA_EN_B_MASK = 8'h57;
  localparam logic [7:0] MIA_PMUX_MASK = 8'h0A;
  // field positions
  localparam int MIA_B_PAR = 1;
  localparam int MIA_B_UART_B = 2;
  localparam int MIA_B_UART_A = 3;
  localparam int MIA_B_FLOPPY = 4;
  localparam int MIA_B_WDOG = 7;
  localparam int MIA_B_MOUSE = 0;
  localparam int MIA_B_KBD = 1;
  localparam int MIA_B_IR = 2;
  localparam int MIA_B_KBC = 4;
  localparam int MIA_B_SERIRQ = 6;
  localparam int MIA_B_DMA3 = 1;
  localparam int MIA_B_KBCSEL = 3;
  localparam int MIA_B_FORCE0 = 0;
endpackage

// ---- mia_aggregator.sv ----
/*
  management interrupt aggregator: status, enables, group interrupt,
  serial irq forwarding, pin multiplex control and forced media change.
  holds the two enable registers, the live status views, the sticky
  infrared activity flag, the standby-domain reserved register, the pin
  multiplex register and the forced media-change register.
  assumes pin-side inputs are asynchronous; all but drive select, media change and infrared select are synchronised here; the
  register port is on i_mclk with read data one cycle after the strobe.
  assumes the standby reset comes from an always-on supply and the main
  reset from the main supply; both release synchronously to i_mclk.
  assumes the host never raises read and write strobes together.
*/
// The plain strobed port was decided locally.
// How it works
// - enable a gates parallel, uarts, floppy, watchdog
// - enable b gates mouse, keyboard, infrared
// - enable b bit4 routes kbc output
// - enable b bit6 forwards onto serial irq
// - status a shows sources, cleared at source
// - status b shows mouse, keyboard, kbc output
// - infrared edge sets activity flag
// - reading status b clears infrared flag
// - enables and status reset to zero
// - forced bit write-one-set only, resets 03
// - index b8 reserved, zero on standby reset
// - step with select clears forced bit
`timescale 1ns/10ps
module mia_aggregator
  import mia_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_stby_rst_b,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_par_req,
  input wire logic i_uart_b_req,
  input wire logic i_uart_a_req,
  input wire logic i_floppy_req,
  input wire logic i_watchdog_req,
  input wire logic i_mouse_req,
  input wire logic i_kbd_req,
  input wire logic i_kbc_port1_bit2_out,
  input wire logic i_uart_b_rx_in,
  input wire logic i_infrared_rx_in,
  input wire logic i_ir_sel_infrared,
  input wire logic i_drive_step_n,
  input wire logic i_drive_select_zero_n,
  input wire logic i_media_changed_in_n,
  output logic o_mgmt_irq_n,
  output logic o_mgmt_serial_irq,
  output logic o_media_changed_status,
  output logic o_dma3_select,
  output logic o_kbc_select
);
  localparam int NSYNC = 11;
  // slot of each pin input inside the synchroniser bank
  localparam int SY_STEP = 0;
  localparam int SY_IR_RX = 1;
  localparam int SY_UART_RX = 2;
  localparam int SY_KBC = 3;
  localparam int SY_KBD = 4;
  localparam int SY_MOUSE = 5;
  localparam int SY_WDOG = 6;
  localparam int SY_FLOPPY = 7;
  localparam int SY_UART_A = 8;
  localparam int SY_UART_B = 9;
  localparam int SY_PAR = 10;
  // reset image of the bank: idle-high lines (step strobe, uart rx) start
  // high so no false step is seen while the bank fills
  localparam logic [NSYNC-1:0] SY_IDLE = 11'h005;
  // edges seen before the bank and the edge register hold real samples
  // are artefacts of reset, so the infrared detector waits this long
  localparam logic [1:0] IR_WARM_CYCLES = 2'h3;

  // timing of a source, counted in enabled clock edges:
  //   edge 1 and 2: the pin level walks through the two sync flops
  //   edge 2 on:    the live status bit shows the new level
  //   edge 3:       the group output and the serial forward follow
  // so a source that pulses for less than one clock may be missed;
  // sources are expected to hold their request until software clears
  // them at the origin, which suits the cleared-at-source status.
  //
  // infrared flag:
  //   edge 3:       the edge register compares against the new level
  //   edge 4:       the group output follows if the flag is enabled
  // the flag is the only sticky status bit; a read of status b clears
  // it, and a new edge in the same cycle keeps it set so no activity
  // is lost between the read and the clear.
  //
  // drive select and media-change input are used as they arrive; they
  // are slow levels that only feed the forced-bit clear and the
  // registered media status, and a one-cycle glitch there only delays
  // the clear or the status by a cycle.
  //
  // a low clock enable freezes every flop, the sync bank included.

  // register file
  logic [7:0] en_a_q;
  logic [7:0] en_b_q;
  logic [7:0] pmux_q;
  logic [7:0] fmc_q;
  logic [7:0] rsvd_q;

  // infrared detector state
  logic ir_flag_q;
  logic ir_prev_q;
  logic [1:0] ir_warm_q;
  logic ir_armed;
  logic ir_sel;

  // output flops
  logic [7:0] rdata_q;
  logic irq_n_q;
  logic ser_q;
  logic media_changed_status_q;

  // synchroniser bank and live status
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] raw;
  logic [7:0] st_a;
  logic [7:0] st_b;

  // group request terms
  logic grp_a;
  logic grp_mouse;
  logic grp_kbd;
  logic grp_ir;
  logic grp_kbc;
  logic grp;

  // pin inputs gathered in bank order, highest slot first
  assign raw = {i_par_req, i_uart_b_req, i_uart_a_req, i_floppy_req, i_watchdog_req,
                i_mouse_req, i_kbd_req, i_kbc_port1_bit2_out, i_uart_b_rx_in,
                i_infrared_rx_in, i_drive_step_n};

  // two-stage synchroniser per pin input; only the second flop is read
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          s1_q[g] <= SY_IDLE[g];
          s2_q[g] <= SY_IDLE[g];
        end else if (i_ce) begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  // status follows sources live, cleared only at the source, except the sticky infrared flag;
  // no latch here, so a masked source can still be polled
  always_comb begin
    // group a: parallel, both uarts, floppy, watchdog
    st_a = 8'h00;
    st_a[MIA_B_PAR] = s2_q[SY_PAR];
    st_a[MIA_B_UART_B] = s2_q[SY_UART_B];
    st_a[MIA_B_UART_A] = s2_q[SY_UART_A];
    st_a[MIA_B_FLOPPY] = s2_q[SY_FLOPPY];
    st_a[MIA_B_WDOG] = s2_q[SY_WDOG];
    // group b: mouse, keyboard, infrared flag, kbc output
    st_b = 8'h00;
    st_b[MIA_B_MOUSE] = s2_q[SY_MOUSE];
    st_b[MIA_B_KBD] = s2_q[SY_KBD];
    st_b[MIA_B_IR] = ir_flag_q;
    st_b[MIA_B_KBC] = s2_q[SY_KBC];
    // unlisted bits stay zero and read back as zero
  end

  // rx line chosen after the mux
  assign ir_sel = i_ir_sel_infrared ? s2_q[SY_IR_RX] : s2_q[SY_UART_RX];

  // warm-up counter: holds off the infrared detector after reset
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ir_warm_q <= 2'h0;
    end else if (i_ce && !ir_armed) begin
      ir_warm_q <= ir_warm_q + 2'h1;
    end
  end

  // detector armed once the bank and edge register are filled
  assign ir_armed = (ir_warm_q == IR_WARM_CYCLES);

  // infrared activity flag; a new edge wins over the read clear
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ir_prev_q <= 1'b0;
      ir_flag_q <= 1'b0;
    end else if (i_ce) begin
      ir_prev_q <= ir_sel;
      if (ir_armed && ir_sel != ir_prev_q) begin
        ir_flag_q <= 1'b1;
      end else if (i_rd && i_addr == MIA_IDX_ST_B) begin
        ir_flag_q <= 1'b0;
      end
    end
  end

  // enable and pin mux registers
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_a_q <= MIA_RST_ZERO;
      en_b_q <= MIA_RST_ZERO;
      pmux_q <= MIA_RST_PMUX;
    end else if (i_ce && i_wr) begin
      if (i_addr == MIA_IDX_EN_A) begin
        en_a_q <= i_wdata & MIA_EN_A_MASK;
      end
      if (i_addr == MIA_IDX_EN_B) begin
        en_b_q <= i_wdata & MIA_EN_B_MASK;
      end
      if (i_addr == MIA_IDX_PMUX) begin
        pmux_q <= i_wdata & MIA_PMUX_MASK;
      end
    end
  end

  // reserved register lives in the standby domain; holds no bits
  always_ff @(posedge i_mclk or negedge i_stby_rst_b) begin
    if (!i_stby_rst_b) begin
      rsvd_q <= MIA_RST_ZERO;
    end else if (i_ce) begin
      rsvd_q <= MIA_RST_ZERO;
    end
  end

  // forced media change: software may only set; a step on drive 0 clears
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fmc_q <= MIA_RST_FMC;
    end else if (i_ce) begin
      if (i_wr && i_addr == MIA_IDX_FMC && i_wdata[MIA_B_FORCE0]) begin
        fmc_q[MIA_B_FORCE0] <= 1'b1;
      end else if (!s2_q[SY_STEP] && !i_drive_select_zero_n) begin
        fmc_q[MIA_B_FORCE0] <= 1'b0;
      end
    end
  end

  // group a as one term and group b per source, kept apart so each gate is easy to probe
  assign grp_a = |(st_a & en_a_q);
  assign grp_mouse = st_b[MIA_B_MOUSE] & en_b_q[MIA_B_MOUSE];
  assign grp_kbd = st_b[MIA_B_KBD] & en_b_q[MIA_B_KBD];
  assign grp_ir = st_b[MIA_B_IR] & en_b_q[MIA_B_IR];
  // kbc output contributes only while routed in
  assign grp_kbc = st_b[MIA_B_KBC] & en_b_q[MIA_B_KBC];

  // group request: any enabled source
  assign grp = grp_a | grp_mouse | grp_kbd | grp_ir | grp_kbc;

  // registered outputs
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_n_q <= 1'b1;
      ser_q <= 1'b0;
      media_changed_status_q <= 1'b0;
    end else if (i_ce) begin
      irq_n_q <= ~grp;
      ser_q <= grp & en_b_q[MIA_B_SERIRQ];
      media_changed_status_q <= (i_drive_select_zero_n & fmc_q[MIA_B_FORCE0]) | i_media_changed_in_n;
    end
  end

  // read data one cycle after the strobe, zero otherwise or unmapped;
  // zeroing between reads keeps a stale value from looking like an
  // answer to a strobe that never came
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      rdata_q <= 8'h00;
      if (i_rd) begin
        unique case (i_addr)
          MIA_IDX_EN_A: rdata_q <= en_a_q;
          MIA_IDX_EN_B: rdata_q <= en_b_q;
          MIA_IDX_ST_A: rdata_q <= st_a;
          MIA_IDX_ST_B: rdata_q <= st_b;
          MIA_IDX_RSVD: rdata_q <= rsvd_q;
          MIA_IDX_PMUX: rdata_q <= pmux_q;
          MIA_IDX_FMC: rdata_q <= fmc_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // data outputs straight from flops; pin mux selects from the register
  assign o_rdata = rdata_q;
  assign o_mgmt_irq_n = irq_n_q;
  assign o_mgmt_serial_irq = ser_q;
  assign o_media_changed_status = media_changed_status_q;
  assign o_dma3_select = pmux_q[MIA_B_DMA3];
  assign o_kbc_select = pmux_q[MIA_B_KBCSEL];
endmodule

// ---- mia_host_model.sv ----
/* host model: samples the group interrupt as a chipset input.
   assumes the aggregator's clock. */
`timescale 1ns/10ps
module mia_host_model (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_mgmt_irq_n,
  output logic o_irq_seen
);
  // one sample a clock, no filtering
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq_seen <= 1'b0;
    end else begin
      o_irq_seen <= !i_mgmt_irq_n;
    end
  end
endmodule

// ---- mia_aggregator_properties.sv ----
/* port checker for the aggregator.
   assumes the bind below and one clock. */
`timescale 1ns/10ps
module mia_aggregator_properties
  import mia_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_drive_select_zero_n,
  input wire logic i_media_changed_in_n,
  input wire logic o_media_changed_status,
  input wire logic o_dma3_select
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // past reset guard: outputs still hold reset values at the first edge
  chk_rdata_idle: assert property (!$past(i_rd && i_ce) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_rsvd_zero: assert property (
    $past(i_rd && i_ce && i_addr == MIA_IDX_RSVD) |-> o_rdata == 8'h00)
    else $error("reserved index not zero");
  chk_st_a_rsvd: assert property (
    $past(i_rd && i_ce && i_addr == MIA_IDX_ST_A) |-> (o_rdata & 8'h61) == 8'h00)
    else $error("status a reserved bits set");
  chk_st_b_rsvd: assert property (
    $past(i_rd && i_ce && i_addr == MIA_IDX_ST_B) |-> (o_rdata & 8'hE8) == 8'h00)
    else $error("status b reserved bits set");
  chk_pmux_write: assert property (
    $past(i_rst_b && i_ce && i_wr && i_addr == MIA_IDX_PMUX) |-> o_dma3_select == $past(i_wdata[1]))
    else $error("dma3 select missed write");
  chk_pmux_hold: assert property (
    $past(i_rst_b) && !$past(i_wr && i_addr == MIA_IDX_PMUX) |-> $stable(o_dma3_select))
    else $error("dma3 select moved");
  chk_media_set: assert property (
    $past(i_rst_b && i_ce && i_media_changed_in_n) |-> o_media_changed_status)
    else $error("media status not set");
  chk_media_clear: assert property (
    $past(i_rst_b && i_ce && !i_drive_select_zero_n && !i_media_changed_in_n)
    |-> !o_media_changed_status)
    else $error("media status not clear");
endmodule
bind mia_aggregator mia_aggregator_properties u_props(.i_mclk, .i_rst_b, .i_ce, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_drive_select_zero_n, .i_media_changed_in_n,
  .o_media_changed_status, .o_dma3_select);

// ---- tb_top.sv ----
/* testbench: register tasks, source sweeps, media change.
   assumes the checker is bound in. */
`timescale 1ns/10ps
module tb_top;
  import mia_pkg::*;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, ir = 0, stp = 1, ds0 = 1, mch = 0, ser, seen, irq_n;
  logic dma3, kbcs, mstat;
  logic [7:0] addr = 0, wd = 0, rdat, sa = 0, sb = 0;
  int mismatches = 0, cmp_count = 0;
  int bl[3] = '{0, 1, 4};
  initial forever #50 clk = ~clk;
  mia_aggregator u_dut(.i_mclk(clk), .i_rst_b(rst_b), .i_stby_rst_b(rst_b), .i_ce(1'b1),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_par_req(sa[1]),
    .i_uart_b_req(sa[2]), .i_uart_a_req(sa[3]), .i_floppy_req(sa[4]), .i_watchdog_req(sa[7]),
    .i_mouse_req(sb[0]), .i_kbd_req(sb[1]), .i_kbc_port1_bit2_out(sb[4]),
    .i_uart_b_rx_in(1'b1), .i_infrared_rx_in(ir), .i_ir_sel_infrared(1'b1),
    .i_drive_step_n(stp), .i_drive_select_zero_n(ds0), .i_media_changed_in_n(mch),
    .o_mgmt_irq_n(irq_n), .o_mgmt_serial_irq(ser), .o_media_changed_status(mstat),
    .o_dma3_select(dma3), .o_kbc_select(kbcs));
  mia_host_model u_host(.i_mclk(clk), .i_rst_b(rst_b), .i_mgmt_irq_n(irq_n), .o_irq_seen(seen));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data looked at only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", rdat, e);
  endtask
  // sources cross two sync flops, edge register and output flops
  task automatic settle;
    repeat (6) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(MIA_IDX_EN_A, 8'h00);
    rd_chk(MIA_IDX_EN_B, 8'h00);
    rd_chk(MIA_IDX_ST_B, 8'h00);
    rd_chk(MIA_IDX_ST_A, 8'h00);
    rd_chk(MIA_IDX_PMUX, 8'h02);
    chk("dma3", {7'h00, dma3}, 8'h01);
    chk("kbcsel", {7'h00, kbcs}, 8'h00);
    rd_chk(MIA_IDX_FMC, 8'h03);
    wr_reg(MIA_IDX_RSVD, 8'hFF);
    wr_reg(MIA_IDX_PMUX, 8'hFF);
    rd_chk(MIA_IDX_RSVD, 8'h00);
    rd_chk(MIA_IDX_PMUX, 8'h0A);
    chk("dma3", {7'h00, dma3}, 8'h01);
    chk("kbcsel", {7'h00, kbcs}, 8'h01);
    rd_chk(8'h10, 8'h00);
    // step with drive 0 selected drops the forced bit
    @(posedge clk);
    stp <= 1'b0;
    ds0 <= 1'b0;
    mch <= 1'b1;
    settle();
    chk("mstat", {7'h00, mstat}, 8'h01);
    @(posedge clk);
    stp <= 1'b1;
    mch <= 1'b0;
    rd_chk(MIA_IDX_FMC, 8'h02);
    chk("mstat", {7'h00, mstat}, 8'h00);
    wr_reg(MIA_IDX_FMC, 8'h00);
    rd_chk(MIA_IDX_FMC, 8'h02);
    wr_reg(MIA_IDX_FMC, 8'h01);
    rd_chk(MIA_IDX_FMC, 8'h03);
    wr_reg(MIA_IDX_EN_A, 8'hFF);
    rd_chk(MIA_IDX_EN_A, 8'h9E);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sa <= 8'h01 << i;
      settle();
      chk("irq_n", {7'h00, irq_n}, {7'h00, !((8'h9E >> i) & 8'h01)});
      rd_chk(MIA_IDX_ST_A, 8'h9E & (8'h01 << i));
    end
    wr_reg(MIA_IDX_EN_A, 8'h00);
    settle();
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd_chk(MIA_IDX_ST_A, 8'h80);
    @(posedge clk);
    sa <= 8'h00;
    wr_reg(MIA_IDX_EN_B, 8'hFF);
    rd_chk(MIA_IDX_EN_B, 8'h57);
    foreach (bl[k]) begin
      @(posedge clk);
      sb <= 8'h01 << bl[k];
      settle();
      chk("irq_n", {7'h00, irq_n}, 8'h00);
      chk("serial", {7'h00, ser}, 8'h01);
      rd_chk(MIA_IDX_ST_B, 8'h01 << bl[k]);
    end
    wr_reg(MIA_IDX_EN_B, 8'h17);
    settle();
    chk("serial", {7'h00, ser}, 8'h00);
    wr_reg(MIA_IDX_EN_B, 8'h07);
    settle();
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    @(posedge clk);
    sb <= 8'h00;
    ir <= 1'b1;
    settle();
    chk("seen", {7'h00, seen}, 8'h01);
    rd_chk(MIA_IDX_ST_B, 8'h04);
    rd_chk(MIA_IDX_ST_B, 8'h00);
    tally_and_finish();
  end
endmodule
